// ---- hw/pas_input.sv ----
module pas_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  wire full = (cnt_q == (AW+1)'(DEPTH));
  wire empty = (cnt_q == '0);
  wire push = in_valid & ~full;
  // Output stage refills when empty or being drained
  wire pop = ~empty & (~out_valid_q | out_ready);

  assign in_ready = ~full;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= push ? wr_q + 1'b1 : wr_q;
      rd_q <= pop ? rd_q + 1'b1 : rd_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered head so outputs come from flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (pop) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem_q[rd_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end
endmodule // pas_fifo

// Overview of operation
// - Classify clock-per-frame ratio 128..768 automatically, no setting needed.
// - After reset count 1024 clocks, then load default mode settings.
// - Shift each data bit in on rising bit clock edge.
// - Frame drift over six bit clocks resyncs within a frame, muted.
// - Right-, left-justified or I2S framing chosen by three-bit format.
// - Default framing after reset is 24-bit I2S until rewritten.
// - Words are two's complement, most significant bit first.
// - In I2S low word clock is left, high is right.
// - In justified formats high word clock is left, low is right.
module pas_input (
  input wire logic clk,
  input wire logic nrst,
  input wire logic serial_bit_clock,
  input wire logic lr_word_clock,
  input wire logic pcm_serial_input,
  input wire logic [2:0] format_select,
  input wire logic format_write,
  output logic sample_valid,
  output logic [pas_pkg::SAMPLE_W-1:0] sample_data,
  output logic sample_left,
  input wire logic sample_ready,
  output logic muted,
  output logic [2:0] ratio_code,
  output logic ratio_ok,
  output logic init_done,
  output logic overrun
);
  import pas_pkg::*;

  // Word length per format
  function automatic logic [4:0] mode_len(input logic [2:0] f);
    case (f)
      MODE_RJ16, MODE_I2S16: mode_len = LEN_16;
      MODE_RJ20: mode_len = LEN_20;
      default: mode_len = LEN_24;
    endcase
  endfunction

  // Framing family tests
  function automatic logic is_i2s(input logic [2:0] f);
    is_i2s = (f == MODE_I2S16) || (f == MODE_I2S24);
  endfunction

  function automatic logic is_rj(input logic [2:0] f);
    is_rj = (f == MODE_RJ16) || (f == MODE_RJ20) || (f == MODE_RJ24);
  endfunction

  // Ratio class from clock cycles per frame, {ok, code}
  function automatic logic [3:0] ratio_of(input logic [11:0] c);
    if (c < RAT_T_LOW || c > RAT_T_HIGH) begin
      ratio_of = {1'b0, RATIO_128};
    end else if (c < RAT_T192) begin
      ratio_of = {1'b1, RATIO_128};
    end else if (c < RAT_T256) begin
      ratio_of = {1'b1, RATIO_192};
    end else if (c < RAT_T384) begin
      ratio_of = {1'b1, RATIO_256};
    end else if (c < RAT_T512) begin
      ratio_of = {1'b1, RATIO_384};
    end else if (c < RAT_T768) begin
      ratio_of = {1'b1, RATIO_512};
    end else begin
      ratio_of = {1'b1, RATIO_768};
    end
  endfunction

  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic bck_d1_q;
  logic lr_d1_q;
  logic lrb_q;
  pas_state_t st_q;
  pas_state_t st_d;
  logic [10:0] init_cnt_q;
  logic [2:0] mode_q;
  logic [SAMPLE_W-1:0] word_q;
  logic [7:0] cnt_q;
  logic [7:0] bpf_q;
  logic [7:0] ref_q;
  logic [11:0] fcnt_q;
  logic pend_v_q;
  logic [FIFO_W-1:0] pend_q;
  logic muted_q;
  logic init_done_q;
  logic overrun_q;
  logic [2:0] ratio_code_q;
  logic ratio_ok_q;
  logic fifo_ready;

  // Pins enter through two flops; only the second stage is read
  wire [2:0] pins = {pcm_serial_input, lr_word_clock, serial_bit_clock};
  wire bck_s = sync2_q[0];
  wire lr_s = sync2_q[1];
  wire dat_s = sync2_q[2];

  // Edge and boundary decode
  wire bck_rise = bck_s & ~bck_d1_q;
  wire lr_rise = lr_s & ~lr_d1_q;
  wire lr_chg = bck_rise & (lr_s != lrb_q);
  wire frame_start = lr_chg & lr_s;
  wire in_init = (st_q == ST_INIT);

  // Framing decode of the active format
  wire [4:0] cur_len = mode_len(mode_q);
  wire cur_i2s = is_i2s(mode_q);
  wire cur_rj = is_rj(mode_q);
  wire [4:0] align_sh = LEN_24 - cur_len;
  wire shift_en = bck_rise & ~lr_chg & ~in_init & (cur_rj | (cnt_q < {3'h0, cur_len}));
  wire [SAMPLE_W-1:0] aligned = word_q << align_sh;
  wire [7:0] diff = (bpf_q > ref_q) ? bpf_q - ref_q : ref_q - bpf_q;
  wire drift = diff > DRIFT_BITS;
  wire [3:0] ratio_now = ratio_of(fcnt_q);

  // Word leaves on every channel boundary; muted words are bipolar zero
  wire emit = lr_chg;
  wire [SAMPLE_W-1:0] emit_data = (st_q == ST_RUN) ? aligned : '0;
  wire emit_left = cur_i2s ? ~lrb_q : lrb_q;
  wire push = pend_v_q & fifo_ready;

  // Synchronizer; word clock timing relies on a steady source
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  // Edge history and channel level sampled at bit clock rise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bck_d1_q <= 1'b0;
      lr_d1_q <= 1'b0;
      lrb_q <= 1'b0;
    end else begin
      bck_d1_q <= bck_s;
      lr_d1_q <= lr_s;
      lrb_q <= bck_rise ? lr_s : lrb_q;
    end
  end

  // Next state: init count, then sync until a frame repeats
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_INIT: st_d = (init_cnt_q == INIT_LAST) ? ST_SYNC : ST_INIT;
      ST_SYNC: st_d = (frame_start && !drift && ref_q != '0) ? ST_RUN : ST_SYNC;
      ST_RUN: st_d = (frame_start && drift) ? ST_SYNC : ST_RUN;
      default: st_d = ST_INIT;
    endcase
  end

  // State and init counter; the counter freezes once init ends
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= ST_INIT;
      init_cnt_q <= '0;
    end else begin
      st_q <= st_d;
      init_cnt_q <= in_init ? init_cnt_q + 1'b1 : init_cnt_q;
    end
  end

  // Format field; held at default until the init count ends
  always_ff @(posedge clk) begin
    if (!nrst || in_init) begin
      mode_q <= MODE_RESET;
    end else if (format_write) begin
      mode_q <= format_select;
    end
  end

  // Deserializer, MSB first; I2S skips the bit under the boundary
  always_ff @(posedge clk) begin
    if (!nrst || in_init) begin
      word_q <= '0;
      cnt_q <= '0;
    end else if (lr_chg) begin
      word_q <= cur_i2s ? '0 : {{(SAMPLE_W-1){1'b0}}, dat_s};
      cnt_q <= cur_i2s ? 8'h00 : 8'h01;
    end else if (shift_en) begin
      word_q <= {word_q[SAMPLE_W-2:0], dat_s};
      cnt_q <= (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 1'b1;
    end
  end

  // Bits per frame against last frame, for drift detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bpf_q <= '0;
      ref_q <= '0;
    end else if (frame_start) begin
      bpf_q <= 8'h01;
      ref_q <= bpf_q;
    end else if (bck_rise && bpf_q != CNT_MAX) begin
      bpf_q <= bpf_q + 1'b1;
    end
  end

  // Ratio: clock cycles per word clock period, classified at each rise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fcnt_q <= '0;
      ratio_code_q <= RATIO_128;
      ratio_ok_q <= 1'b0;
    end else if (lr_rise) begin
      fcnt_q <= 12'h001;
      ratio_code_q <= ratio_now[2:0];
      ratio_ok_q <= ratio_now[3];
    end else begin
      fcnt_q <= (fcnt_q == FCNT_MAX) ? fcnt_q : fcnt_q + 1'b1;
    end
  end

  // Hold slot: bit stream cannot stall, so a full buffer loses a word
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_v_q <= 1'b0;
      pend_q <= '0;
      overrun_q <= 1'b0;
    end else begin
      if (emit) begin
        pend_v_q <= 1'b1;
        pend_q <= {emit_left, emit_data};
      end else if (push) begin
        pend_v_q <= 1'b0;
      end
      overrun_q <= overrun_q | (emit & pend_v_q & ~push);
    end
  end

  // Status flops
  always_ff @(posedge clk) begin
    if (!nrst) begin
      muted_q <= 1'b1;
      init_done_q <= 1'b0;
    end else begin
      muted_q <= (st_q != ST_RUN);
      init_done_q <= ~in_init;
    end
  end

  assign muted = muted_q;
  assign init_done = init_done_q;
  assign overrun = overrun_q;
  assign ratio_code = ratio_code_q;
  assign ratio_ok = ratio_ok_q;

  // Sample buffer toward the filter
  pas_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) i_pas_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(pend_v_q),
    .in_data(pend_q),
    .in_ready(fifo_ready),
    .out_valid(sample_valid),
    .out_data({sample_left, sample_data}),
    .out_ready(sample_ready)
  );

  // Checks on the system clock, off while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Last init cycle, then sync with init_done one edge later
  sequence init_end_s;
    in_init && init_cnt_q == INIT_LAST;
  endsequence

  sequence sync_done_s;
    (st_q == ST_SYNC) ##1 init_done_q;
  endsequence

  init_length_a: assert property (init_end_s |=> sync_done_s)
    else $error("init count did not end in sync");
  init_quiet_a: assert property (in_init |-> !init_done_q && muted_q)
    else $error("outputs active during init");
  mode_default_a: assert property (in_init |=> mode_q == MODE_RESET)
    else $error("format not default during init");
  mode_wr_a: assert property (!in_init && format_write |=> mode_q == $past(format_select))
    else $error("format write not taken");
  shift_edge_a: assert property (!bck_rise && !in_init |=> $stable(word_q))
    else $error("shift without bit clock rise");
  msb_first_a: assert property (
    shift_en |=> word_q == {$past(word_q[SAMPLE_W-2:0]), $past(dat_s)})
    else $error("bit not shifted in at lsb");
  drift_resync_a: assert property (
    st_q == ST_RUN && frame_start && drift |=> st_q == ST_SYNC ##1 muted_q)
    else $error("drift did not force resync");
  mute_zero_a: assert property (emit && st_q != ST_RUN |=> pend_q[SAMPLE_W-1:0] == '0)
    else $error("muted sample not zero");
  chan_map_a: assert property (
    emit |=> pend_q[SAMPLE_W] == ($past(cur_i2s) ^ $past(lrb_q)))
    else $error("channel mapping wrong");
  ratio_256_a: assert property (
    lr_rise && fcnt_q >= RAT_T256 && fcnt_q < RAT_T384
    |=> ratio_code_q == RATIO_256 && ratio_ok_q)
    else $error("ratio class wrong");
endmodule // pas_input

// ---- common/pas_pkg.sv ----
package pas_pkg;
  // Sample and buffer shape
  localparam int SAMPLE_W = 24;
  localparam int FIFO_W = 25;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;

  // Serial framing codes of the format field
  localparam logic [2:0] MODE_RJ16 = 3'h0;
  localparam logic [2:0] MODE_RJ20 = 3'h1;
  localparam logic [2:0] MODE_RJ24 = 3'h2;
  localparam logic [2:0] MODE_LJ24 = 3'h3;
  localparam logic [2:0] MODE_I2S16 = 3'h4;
  localparam logic [2:0] MODE_I2S24 = 3'h5;
  localparam logic [2:0] MODE_RESET = MODE_I2S24;

  // Word lengths in bits
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_20 = 5'h14;
  localparam logic [4:0] LEN_24 = 5'h18;

  // Initialization count in system clock cycles
  localparam int INIT_CYCLES = 1024;
  localparam logic [10:0] INIT_LAST = 11'(INIT_CYCLES - 1);

  // Allowed frame length change in bit clocks
  localparam logic [7:0] DRIFT_BITS = 8'h06;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // Ratio class boundaries, clock cycles per frame (midpoints)
  localparam logic [11:0] RAT_T_LOW = 12'h060;
  localparam logic [11:0] RAT_T192 = 12'h0A0;
  localparam logic [11:0] RAT_T256 = 12'h0E0;
  localparam logic [11:0] RAT_T384 = 12'h140;
  localparam logic [11:0] RAT_T512 = 12'h1C0;
  localparam logic [11:0] RAT_T768 = 12'h280;
  localparam logic [11:0] RAT_T_HIGH = 12'h380;
  localparam logic [11:0] FCNT_MAX = 12'hFFF;

  typedef enum logic [2:0] {
    RATIO_128 = 3'b000,
    RATIO_192 = 3'b001,
    RATIO_256 = 3'b010,
    RATIO_384 = 3'b011,
    RATIO_512 = 3'b100,
    RATIO_768 = 3'b101
  } pas_ratio_t;

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_SYNC = 2'b01,
    ST_RUN = 2'b10
  } pas_state_t;
endpackage

// ---- bench/pas_source.sv ----
module pas_source (
  input wire logic clk,
  output logic bclk,
  output logic lrclk,
  output logic sdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import pas_pkg::*;

  // Quiet lines until the first frame
  initial begin
    bclk = 1'b0;
    lrclk = 1'b0;
    sdata = 1'b0;
  end

  // One channel half; every change rides a clk edge, so the phase to clk is fixed
  task automatic send_half(input logic [23:0] v, input int n, input logic [2:0] mode,
                           input logic lvl, input int slots, input int half);
    int k;
    for (int i = 0; i < slots; i++) begin
      if (mode == MODE_LJ24)
        k = i;
      else if (mode >= MODE_I2S16)
        k = i - 1;
      else
        k = i - (slots - n);
      lrclk <= lvl;
      sdata <= (k >= 0 && k < n) ? v[23 - k] : ~sdata;
      bclk <= 1'b0;
      repeat (half) @(posedge clk);
      bclk <= 1'b1;
      repeat (half) @(posedge clk);
    end
  endtask

  // Whole frame; slip lengthens the second half to move the frame edge
  task automatic send_frame(input logic [23:0] l, input logic [23:0] r, input logic [2:0] mode,
                            input int slots, input int half, input int slip);
    int n;
    logic lft;
    n = (mode == MODE_RJ16 || mode == MODE_I2S16) ? 16 : (mode == MODE_RJ20) ? 20 : 24;
    lft = (mode >= MODE_I2S16) ? 1'b0 : 1'b1;
    send_half(l, n, mode, lft, slots, half);
    send_half(r, n, mode, ~lft, slots + slip, half);
  endtask
endmodule // pas_source

// ---- bench/pas_input_bench.sv ----
module pas_input_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pas_pkg::*;

  localparam logic [23:0] VL = 24'h9A5C3E;
  localparam logic [23:0] VR = 24'h4B71D2;
  logic clk, nrst, bclk, lrclk, sdata, format_write, sample_ready;
  logic [2:0] format_select, ratio_code;
  logic sample_valid, sample_left, muted, ratio_ok, init_done, overrun, mute_seen;
  logic [23:0] sample_data;
  logic [23:0] got_d[$];
  logic got_l[$];
  int err_count = 0;
  int samples_checked = 0;

  pas_input i_pas_input (.clk(clk), .nrst(nrst), .serial_bit_clock(bclk),
    .lr_word_clock(lrclk), .pcm_serial_input(sdata), .format_select(format_select),
    .format_write(format_write), .sample_valid(sample_valid), .sample_data(sample_data),
    .sample_left(sample_left), .sample_ready(sample_ready), .muted(muted),
    .ratio_code(ratio_code), .ratio_ok(ratio_ok), .init_done(init_done), .overrun(overrun));
  pas_source i_pas_source (.clk(clk), .bclk(bclk), .lrclk(lrclk), .sdata(sdata));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // One comparison; an unknown counts as a mismatch
  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // Counts, verdict and end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Collect taken words; words leaving during init must be muted zeros
  always @(posedge clk) begin
    if (muted === 1'b1)
      mute_seen = 1'b1;
    if (nrst === 1'b1 && sample_valid === 1'b1 && sample_ready === 1'b1) begin
      if (init_done !== 1'b1)
        check(sample_data === 24'h000000 && muted === 1'b1, "init word");
      got_d.push_back(sample_data);
      got_l.push_back(sample_left);
    end
  end

  task automatic frames(input int k, input logic [23:0] l, input logic [23:0] r,
                        input logic [2:0] f, input int sl, input int hf, input int sp);
    repeat (k) i_pas_source.send_frame(l, r, f, sl, hf, sp);
  endtask

  // Every word must be the top n bits of its channel value
  task automatic check_words(input logic [23:0] l, input logic [23:0] r, input int n);
    logic [23:0] m;
    m = ~(24'hFFFFFF >> n);
    check(got_d.size() >= 2, "too few words");
    foreach (got_d[i]) check(got_d[i] === (got_l[i] ? (l & m) : (r & m)), "word");
  endtask

  // Init length; a format write inside it must be ignored
  task automatic t_init();
    int cyc;
    cyc = 0;
    fork
      frames(2, 24'h7FFFFF, 24'h800001, MODE_I2S24, 32, 5, 0);
      begin
        repeat (3) @(posedge clk);
        format_select <= MODE_LJ24;
        format_write <= 1'b1;
        @(posedge clk);
        format_write <= 1'b0;
      end
      begin
        while (init_done !== 1'b1 && cyc < 2000) begin
          @(posedge clk);
          cyc++;
        end
      end
    join
    check(cyc >= INIT_CYCLES && cyc <= INIT_CYCLES + 4, "init length");
  endtask

  // Default framing without any write
  task automatic t_default();
    frames(4, VL, VR, MODE_I2S24, 32, 5, 0);
    got_d = {};
    got_l = {};
    frames(2, VL, VR, MODE_I2S24, 32, 5, 0);
    check_words(VL, VR, 24);
  endtask

  // All framing codes; polarity swaps force a resync, hence the long lead
  task automatic t_formats();
    logic [23:0] l, r;
    for (int f = 0; f <= 5; f++) begin
      l = VL ^ 24'(f);
      r = VR + 24'(f);
      format_select <= 3'(f);
      format_write <= 1'b1;
      @(posedge clk);
      format_write <= 1'b0;
      frames(4, l, r, 3'(f), 32, 5, 0);
      got_d = {};
      got_l = {};
      frames(2, l, r, 3'(f), 32, 5, 0);
      check_words(l, r, (f == 0 || f == 4) ? 16 : (f == 1) ? 20 : 24);
    end
  endtask

  // Frame length classes, last row out of range
  task automatic t_ratio();
    int sl[7] = '{8, 16, 16, 32, 32, 32, 32};
    int hf[7] = '{4, 3, 4, 3, 4, 6, 8};
    pas_ratio_t rc[6] = '{RATIO_128, RATIO_192, RATIO_256, RATIO_384, RATIO_512, RATIO_768};
    for (int i = 0; i < 7; i++) begin
      frames(3, VL, VR, MODE_I2S24, sl[i], hf[i], 0);
      if (i < 6)
        check(ratio_code === rc[i] && ratio_ok === 1'b1, "ratio class");
      else
        check(ratio_ok === 1'b0, "ratio range");
    end
  endtask

  // Drift of six is tolerated, eight mutes within a frame then recovers
  task automatic t_drift();
    frames(4, VL, VR, MODE_I2S24, 32, 5, 0);
    mute_seen = 1'b0;
    frames(3, VL, VR, MODE_I2S24, 32, 5, 6);
    frames(1, VL, VR, MODE_I2S24, 32, 5, 0);
    check(mute_seen === 1'b0, "muted at drift 6");
    frames(1, VL, VR, MODE_I2S24, 32, 5, 8);
    fork
      frames(1, VL, VR, MODE_I2S24, 32, 5, 0);
      begin
        repeat (340) @(posedge clk);
        check(muted === 1'b1, "no mute on drift");
      end
    join
    got_d = {};
    got_l = {};
    frames(1, VL, VR, MODE_I2S24, 32, 5, 0);
    check_words(24'h000000, 24'h000000, 24);
    frames(3, VL, VR, MODE_I2S24, 32, 5, 0);
    got_d = {};
    got_l = {};
    frames(2, VL, VR, MODE_I2S24, 32, 5, 0);
    check_words(VL, VR, 24);
  endtask

  // Stall until the buffer overflows, then drain it dry
  task automatic t_overrun();
    sample_ready <= 1'b0;
    frames(6, VL, VR, MODE_I2S24, 32, 5, 0);
    check(overrun === 1'b1 && sample_valid === 1'b1, "no overrun");
    got_d = {};
    sample_ready <= 1'b1;
    repeat (20) @(posedge clk);
    check(got_d.size() >= 8 && sample_valid === 1'b0, "drain");
  endtask

  // Main sequence
  initial begin
    nrst <= 1'b0;
    format_select <= MODE_RJ16;
    format_write <= 1'b0;
    sample_ready <= 1'b1;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_init();
    t_default();
    t_formats();
    t_ratio();
    t_drift();
    t_overrun();
    stop_test();
  end

  // Watchdog; the tests need about 52k cycles, so this leaves wide margin
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule // pas_input_bench
